// ==== hdl/dss_cmd_decode.sv ====
// run and direction decode for one command source setting
`timescale 1ns/1ps
`include "dss_regs.svh"
module dss_cmd_decode import dss_pkg::*; (
	// selected source
	input wire logic [1:0] src,
	// command inputs
	input wire logic fwd_run,
	input wire logic rev_run,
	input wire logic key_run,
	input wire logic key_rev,
	input wire logic ser_run,
	input wire logic ser_rev,
	// decoded command
	output dss_run_t cmd
);
	always_comb begin
		cmd = '0;
		unique case (src)
			`DSS_CMD_KEYPAD: begin
				cmd.run = key_run;
				cmd.rev = key_rev;
			end
			`DSS_CMD_TERM_FR: begin
				// both inputs on cancels the command
				cmd.run = fwd_run ^ rev_run;
				cmd.rev = rev_run & ~fwd_run;
			end
			`DSS_CMD_TERM_RD: begin
				cmd.run = fwd_run;
				cmd.rev = rev_run;
			end
			`DSS_CMD_SERIAL: begin
				cmd.run = ser_run;
				cmd.rev = ser_rev;
			end
		endcase
	end
endmodule : dss_cmd_decode

// ==== hdl/dss_debounce.sv ====
// two-flop synchroniser and shared debounce filter for pin inputs
`timescale 1ns/1ps
`include "dss_regs.svh"
module dss_debounce import dss_pkg::*; #(
	parameter int W = 7,
	parameter int DEB_CYC = 10000
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// raw pins
	input wire logic [W-1:0] pin_raw,
	// filtered levels
	output logic [W-1:0] pin_db
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] last;
		logic [W-1:0] stable;
		logic [31:0] cnt;
	} dss_deb_state_t;

	dss_deb_state_t st_r;
	dss_deb_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_raw;
		st_nxt.s2 = st_r.s1;
		st_nxt.last = st_r.s2;
		// a level must hold unchanged for the full filter time
		if (st_r.s2 != st_r.last || st_r.s2 == st_r.stable) begin
			st_nxt.cnt = 32'h00000000;
		end else if (st_r.cnt >= 32'(DEB_CYC - 1)) begin
			st_nxt.stable = st_r.s2;
			st_nxt.cnt = 32'h00000000;
		end else begin
			st_nxt.cnt = st_r.cnt + 32'h00000001;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pin_db = st_r.stable;
endmodule : dss_debounce

// ==== hdl/dss_selector.sv ====
// primary and secondary command and frequency source selection with output ramp
`timescale 1ns/1ps
`include "dss_regs.svh"
module dss_selector import dss_pkg::*; #(
	parameter bit ADVANCED_IO = 1'b1,
	parameter int DEB_CYC = `DSS_DEB_TIME_US * `DSS_CLK_MHZ
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// setting writes
	input wire logic cfg_wr,
	input wire logic [3:0] cfg_addr,
	input wire logic [4:0] cfg_data,
	output logic cfg_err,
	// setting readback
	output dss_pair_t primary_pair,
	output dss_pair_t secondary_pair,
	output logic [DSS_NIN-1:0][4:0] input_function_cfg,
	// terminal pins
	input wire logic [DSS_NIN-1:0] digital_input_pins,
	input wire logic forward_run_input,
	input wire logic reverse_run_input,
	// keypad
	input wire logic key_run_press,
	input wire logic key_stop_press,
	input wire logic key_rev,
	// serial link
	input wire logic ser_run,
	input wire logic ser_rev,
	// frequency references
	input wire dss_refs_t refs,
	// ramp rates in clock cycles per frequency step
	input wire logic [15:0] acc_step_cyc,
	input wire logic [15:0] dec_step_cyc,
	// status
	output logic alt_source_select_function,
	output logic alt_selector_assigned,
	output dss_pair_t active_pair,
	output dss_run_t run_cmd,
	output logic [DSS_FW-1:0] out_freq,
	output logic out_rev,
	output dss_ramp_t ramp_state
);
	localparam int NUSE = ADVANCED_IO ? `DSS_ADV_INPUTS : `DSS_STD_INPUTS;

	function automatic logic dss_cmd_ok(input logic [4:0] code);
		logic ok;
		ok = (code <= 5'(`DSS_CMD_MAX));
		if (!ADVANCED_IO && code[1:0] == `DSS_CMD_SERIAL) begin
			ok = 1'b0;
		end
		return ok;
	endfunction : dss_cmd_ok

	function automatic logic dss_frq_ok(input logic [4:0] code);
		logic ok;
		ok = (code <= 5'(`DSS_FRQ_MAX));
		if (!ADVANCED_IO) begin
			unique case (code[3:0])
				`DSS_FRQ_I2_CUR, `DSS_FRQ_I2_VOLT, `DSS_FRQ_POT_I2_CUR,
				`DSS_FRQ_POT_I2_VOLT, `DSS_FRQ_SERIAL: ok = 1'b0;
				default: ok = ok;
			endcase
		end
		return ok;
	endfunction : dss_frq_ok

	function automatic logic [DSS_FW-1:0] dss_sat_add(
		input logic [DSS_FW-1:0] a,
		input logic [DSS_FW-1:0] b
	);
		logic [DSS_FW:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[DSS_FW] ? {DSS_FW{1'b1}} : s[DSS_FW-1:0];
	endfunction : dss_sat_add

	dss_state_t st_r;
	dss_state_t st_nxt;

	logic [DSS_NIN-1:0] di_db;
	logic fwd_db;
	logic rev_db;
	logic [DSS_NIN-1:0] sel_is_fn;
	logic [DSS_NIN-1:0] sel_on;
	logic [DSS_FW-1:0] frq_sel;
	logic [DSS_FW-1:0] tgt;
	logic [15:0] step;
	logic wr_ok;
	logic [3:0] fn_idx;
	dss_run_t dec_cmd;

	// synchronise and filter every pin before use
	dss_debounce #(
		.W(DSS_NIN + 2),
		.DEB_CYC(DEB_CYC)
	) u_debounce (
		.clk(clk),
		.srst(srst),
		.pin_raw({reverse_run_input, forward_run_input, digital_input_pins}),
		.pin_db({rev_db, fwd_db, di_db})
	);

	// decode the command of the active pair
	dss_cmd_decode u_cmd_decode (
		.src(st_r.act.cmd),
		.fwd_run(fwd_db),
		.rev_run(rev_db),
		.key_run(st_r.key_run),
		.key_rev(key_rev),
		.ser_run(ser_run),
		.ser_rev(ser_rev),
		.cmd(dec_cmd)
	);

	// find the inputs assigned as selector
	generate
		for (genvar i = 0; i < DSS_NIN; i++) begin : g_sel
			if (i < NUSE) begin : g_used
				assign sel_is_fn[i] = (st_r.fn[i] == `DSS_FN_ALT_SRC);
				assign sel_on[i] = sel_is_fn[i] & di_db[i];
			end else begin : g_absent
				assign sel_is_fn[i] = 1'b0;
				assign sel_on[i] = 1'b0;
			end
		end
	endgenerate

	// write validation
	always_comb begin
		fn_idx = cfg_addr - `DSS_CFG_FN0;
		wr_ok = 1'b0;
		unique case (cfg_addr)
			`DSS_CFG_CMD1, `DSS_CFG_CMD2: wr_ok = dss_cmd_ok(cfg_data);
			`DSS_CFG_FRQ1, `DSS_CFG_FRQ2: wr_ok = dss_frq_ok(cfg_data);
			default: begin
				if (cfg_addr >= `DSS_CFG_FN0 && cfg_addr <= `DSS_CFG_FN4) begin
					wr_ok = (cfg_data <= `DSS_FN_MAX)
						&& (32'(fn_idx) < NUSE);
				end
			end
		endcase
	end

	// frequency reference of the active pair
	always_comb begin
		frq_sel = '0;
		unique case (st_r.act.frq)
			`DSS_FRQ_KEY1: frq_sel = refs.key1;
			`DSS_FRQ_KEY2: frq_sel = refs.key2;
			`DSS_FRQ_POT: frq_sel = refs.pot;
			`DSS_FRQ_V1: frq_sel = refs.v1;
			`DSS_FRQ_I2_CUR: frq_sel = refs.i2_cur;
			`DSS_FRQ_I2_VOLT: frq_sel = refs.i2_volt;
			`DSS_FRQ_POT_I2_CUR: frq_sel = dss_sat_add(refs.pot, refs.i2_cur);
			`DSS_FRQ_POT_I2_VOLT: frq_sel = dss_sat_add(refs.pot, refs.i2_volt);
			`DSS_FRQ_POT_V1: frq_sel = dss_sat_add(refs.pot, refs.v1);
			`DSS_FRQ_SERIAL: frq_sel = refs.serial;
			`DSS_FRQ_UPDOWN: frq_sel = refs.updown;
			default: frq_sel = '0;
		endcase
	end

	// ramp target: zero on stop, and zero first when direction must reverse
	always_comb begin
		tgt = st_r.cmd.run ? frq_sel : '0;
		if (st_r.cmd.rev != st_r.rev && st_r.freq != '0) begin
			tgt = '0;
		end
		step = (st_r.ramp == DSS_RAMP_DEC) ? dec_step_cyc : acc_step_cyc;
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.cfg_err = 1'b0;

		// setting writes
		if (cfg_wr) begin
			if (!wr_ok) begin
				st_nxt.cfg_err = 1'b1;
			end else begin
				unique case (cfg_addr)
					`DSS_CFG_CMD1: st_nxt.pri.cmd = cfg_data[1:0];
					`DSS_CFG_FRQ1: st_nxt.pri.frq = cfg_data[3:0];
					`DSS_CFG_CMD2: st_nxt.sec.cmd = cfg_data[1:0];
					`DSS_CFG_FRQ2: st_nxt.sec.frq = cfg_data[3:0];
					default: st_nxt.fn[fn_idx[2:0]] = cfg_data;
				endcase
			end
		end

		// pick the pair; both sources move in the same cycle
		st_nxt.alt = |sel_on;
		st_nxt.act = st_nxt.alt ? st_r.sec : st_r.pri;

		// keypad run latch, only live while the keypad commands
		if (st_r.act.cmd != `DSS_CMD_KEYPAD) begin
			st_nxt.key_run = 1'b0;
		end else if (key_stop_press) begin
			st_nxt.key_run = 1'b0;
		end else if (key_run_press) begin
			st_nxt.key_run = 1'b1;
		end

		st_nxt.cmd = dec_cmd;

		// output ramp
		if (st_r.freq < tgt) begin
			st_nxt.ramp = DSS_RAMP_ACC;
		end else if (st_r.freq > tgt) begin
			st_nxt.ramp = DSS_RAMP_DEC;
		end else if (st_r.freq == '0) begin
			st_nxt.ramp = DSS_RAMP_STOP;
		end else begin
			st_nxt.ramp = DSS_RAMP_HOLD;
		end

		unique case (st_r.ramp)
			DSS_RAMP_ACC, DSS_RAMP_DEC: begin
				if (st_nxt.ramp != st_r.ramp) begin
					st_nxt.cnt = 16'h0000;
				end else if (st_r.cnt + 16'h0001 >= step) begin
					st_nxt.cnt = 16'h0000;
					if (st_r.ramp == DSS_RAMP_ACC) begin
						st_nxt.freq = st_r.freq + 1'b1;
					end else begin
						st_nxt.freq = st_r.freq - 1'b1;
					end
				end else begin
					st_nxt.cnt = st_r.cnt + 16'h0001;
				end
			end
			DSS_RAMP_STOP, DSS_RAMP_HOLD: begin
				st_nxt.cnt = 16'h0000;
			end
		endcase

		// direction changes only at standstill
		if (st_r.freq == '0) begin
			st_nxt.rev = st_r.cmd.rev;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0;
			st_r.pri.cmd <= `DSS_CMD_RST;
			st_r.pri.frq <= `DSS_FRQ_RST;
			st_r.sec.cmd <= `DSS_CMD_RST;
			st_r.sec.frq <= `DSS_FRQ_RST;
			st_r.act.cmd <= `DSS_CMD_RST;
			st_r.act.frq <= `DSS_FRQ_RST;
			st_r.fn <= {DSS_NIN{`DSS_FN_RST}};
			st_r.ramp <= DSS_RAMP_STOP;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs
	assign cfg_err = st_r.cfg_err;
	assign primary_pair = st_r.pri;
	assign secondary_pair = st_r.sec;
	assign input_function_cfg = st_r.fn;
	assign alt_source_select_function = st_r.alt;
	assign alt_selector_assigned = |sel_is_fn;
	assign active_pair = st_r.act;
	assign run_cmd = st_r.cmd;
	assign out_freq = st_r.freq;
	assign out_rev = st_r.rev;
	assign ramp_state = st_r.ramp;
endmodule : dss_selector

// ==== inc/dss_pkg.sv ====
// types shared by the dual source selector
package dss_pkg;

	localparam int DSS_FW = 16;
	localparam int DSS_NIN = 5;

	typedef struct packed {
		logic [1:0] cmd;
		logic [3:0] frq;
	} dss_pair_t;

	typedef struct packed {
		logic run;
		logic rev;
	} dss_run_t;

	typedef struct packed {
		logic [DSS_FW-1:0] key1;
		logic [DSS_FW-1:0] key2;
		logic [DSS_FW-1:0] pot;
		logic [DSS_FW-1:0] v1;
		logic [DSS_FW-1:0] i2_cur;
		logic [DSS_FW-1:0] i2_volt;
		logic [DSS_FW-1:0] serial;
		logic [DSS_FW-1:0] updown;
	} dss_refs_t;

	typedef enum logic [1:0] {
		DSS_RAMP_STOP = 2'b00,
		DSS_RAMP_ACC = 2'b01,
		DSS_RAMP_DEC = 2'b10,
		DSS_RAMP_HOLD = 2'b11
	} dss_ramp_t;

	typedef struct packed {
		dss_pair_t pri;
		dss_pair_t sec;
		logic [DSS_NIN-1:0][4:0] fn;
		logic cfg_err;
		logic key_run;
		logic alt;
		dss_pair_t act;
		dss_run_t cmd;
		logic [DSS_FW-1:0] freq;
		logic rev;
		logic [15:0] cnt;
		dss_ramp_t ramp;
	} dss_state_t;

endpackage : dss_pkg

// ==== inc/dss_regs.svh ====
// constants for the dual source selector
// What this block does
// - an input whose function setting is 22 becomes the secondary-source selector
// - with no input assigned as selector, primary command and frequency sources are used
// - selector off: command and frequency sources both come from the primary settings
// - selector on: both sources come from the secondary settings, switching together
// - command source 0 keypad, 1 fwd/rev inputs, 2 run plus direction, 3 serial
// - frequency source 0-1 keypad, 2-5 analog, 6-8 analog mixes, 9 serial, 10 up/down
// - serial command, current, second voltage, pot plus input 2 mixes and serial frequency: advanced only
// - inputs four and five are configurable only on the advanced variant
// - input function settings accept values 0 through 27
// - with run present, output ramps to the set frequency at the acceleration rate
// - secondary terminal mode keeps running while the forward input stays on
// - back on primary, the primary run state is followed; a stop decelerates
// - secondary terminal mode with forward input off decelerates and stops
// - command settings reset to 1, frequency settings reset to 0
`ifndef DSS_REGS_SVH
`define DSS_REGS_SVH

`define DSS_FN_ALT_SRC 5'h16
`define DSS_FN_MAX 5'h1B
`define DSS_FN_RST 5'h00
`define DSS_CMD_MAX 2'h3
`define DSS_FRQ_MAX 4'hA
`define DSS_CMD_RST 2'h1
`define DSS_FRQ_RST 4'h0

`define DSS_CMD_KEYPAD 2'h0
`define DSS_CMD_TERM_FR 2'h1
`define DSS_CMD_TERM_RD 2'h2
`define DSS_CMD_SERIAL 2'h3

`define DSS_FRQ_KEY1 4'h0
`define DSS_FRQ_KEY2 4'h1
`define DSS_FRQ_POT 4'h2
`define DSS_FRQ_V1 4'h3
`define DSS_FRQ_I2_CUR 4'h4
`define DSS_FRQ_I2_VOLT 4'h5
`define DSS_FRQ_POT_I2_CUR 4'h6
`define DSS_FRQ_POT_I2_VOLT 4'h7
`define DSS_FRQ_POT_V1 4'h8
`define DSS_FRQ_SERIAL 4'h9
`define DSS_FRQ_UPDOWN 4'hA

`define DSS_CFG_CMD1 4'h0
`define DSS_CFG_FRQ1 4'h1
`define DSS_CFG_CMD2 4'h2
`define DSS_CFG_FRQ2 4'h3
`define DSS_CFG_FN0 4'h4
`define DSS_CFG_FN4 4'h8

`define DSS_STD_INPUTS 3
`define DSS_ADV_INPUTS 5

`define DSS_CLK_MHZ 10
`define DSS_DEB_TIME_US 1000

`endif

// ==== tb/dss_far_model.sv ====
// keypad, analog and serial sources seen by the selector
`timescale 1ns/1ps
module dss_far_model import dss_pkg::*; (
	// clock
	input wire logic clk,
	// requested source levels
	input wire logic [DSS_FW-1:0] level,
	input wire logic ser_on,
	// source outputs
	output dss_refs_t refs,
	output logic ser_run,
	output logic ser_rev
);
	// serial host updates its run level one cycle late
	always @(posedge clk) begin
		ser_run <= ser_on;
	end
	assign ser_rev = 1'b0;
	assign refs = {8{level}};
endmodule : dss_far_model

// ==== tb/dss_selector_chk.sv ====
// assertions on the dual source selector ports
`timescale 1ns/1ps
module dss_selector_chk import dss_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// settings
	input wire logic cfg_wr,
	input wire logic [3:0] cfg_addr,
	input wire logic [4:0] cfg_data,
	input wire logic cfg_err,
	input wire dss_pair_t primary_pair,
	input wire dss_pair_t secondary_pair,
	input wire logic [DSS_NIN-1:0][4:0] input_function_cfg,
	// status
	input wire logic alt_source_select_function,
	input wire logic alt_selector_assigned,
	input wire dss_pair_t active_pair,
	input wire logic [DSS_FW-1:0] out_freq,
	input wire dss_ramp_t ramp_state
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_reset_value: assert property (disable iff (1'b0) srst |=> primary_pair == 6'h10 &&
		secondary_pair == 6'h10 && active_pair == 6'h10) else $error("reset values wrong");
	a_cmd_range: assert property (cfg_wr && (cfg_addr == 4'h0 || cfg_addr == 4'h2)
		&& cfg_data > 5'h03 |=> cfg_err) else $error("bad command setting accepted");
	a_frq_range: assert property (cfg_wr && (cfg_addr == 4'h1 || cfg_addr == 4'h3)
		&& cfg_data > 5'h0A |=> cfg_err) else $error("bad frequency setting accepted");
	a_fn_range: assert property (cfg_wr && cfg_addr inside {[4'h4:4'h8]} && cfg_data > 5'h1B
		|=> cfg_err) else $error("bad function setting accepted");
	a_sel_assign: assert property (input_function_cfg[4] == 5'h16
		|| input_function_cfg[0] == 5'h16 |-> alt_selector_assigned)
		else $error("function 22 not seen as selector");
	a_unassigned: assert property (!alt_selector_assigned [*3] |-> !alt_source_select_function)
		else $error("secondary used with no selector");
	a_pri_pair: assert property (!alt_source_select_function && $stable(primary_pair)
		|-> active_pair == primary_pair) else $error("primary pair not in use");
	a_sec_pair: assert property (alt_source_select_function && $stable(secondary_pair)
		|-> active_pair == secondary_pair) else $error("secondary pair not in use");
	a_acc_step: assert property (ramp_state == DSS_RAMP_ACC && $past(ramp_state) == DSS_RAMP_ACC
		&& $changed(out_freq) |-> out_freq == $past(out_freq) + 16'h1) else $error("bad acc step");
	a_stop_zero: assert property (ramp_state == DSS_RAMP_STOP |-> out_freq == 16'h0)
		else $error("stopped with output");
endmodule : dss_selector_chk

// ==== tb/tb_dss_selector.sv ====
// self-checking bench for the dual source selector
`timescale 1ns/1ps
module tb_dss_selector import dss_pkg::*;;
	logic clk = 0, srst = 1, cfg_wr = 0, fwd = 0, ser_on = 0, cfg_err, alt, assigned;
	logic ser_run, ser_rev, orev;
	logic rev = 0, kr = 0, ks = 0, krev = 0, err_std, alt_std;
	logic [3:0] cfg_addr = 0;
	logic [4:0] cfg_data = 0, pins = 0;
	logic [15:0] level = 16'h3, acc = 16'h1, freq;
	logic [4:0][4:0] fn;
	dss_pair_t pri, sec, act;
	dss_run_t run;
	dss_ramp_t ramp;
	dss_refs_t refs;
	int err_count = 0, tests_run = 0, seed = 32'h12d1, mpri = 16, msec = 16;
	always #50 clk = ~clk;
	dss_far_model far (.clk(clk), .level(level), .ser_on(ser_on), .refs(refs),
		.ser_run(ser_run), .ser_rev(ser_rev));
	dss_selector #(.DEB_CYC(4)) dut (.clk(clk), .srst(srst), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_data(cfg_data), .cfg_err(cfg_err), .primary_pair(pri),
		.secondary_pair(sec), .input_function_cfg(fn), .digital_input_pins(pins),
		.forward_run_input(fwd), .reverse_run_input(rev), .key_run_press(kr),
		.key_stop_press(ks), .key_rev(krev), .ser_run(ser_run), .ser_rev(ser_rev),
		.refs(refs), .acc_step_cyc(acc), .dec_step_cyc(acc),
		.alt_source_select_function(alt), .alt_selector_assigned(assigned),
		.active_pair(act), .run_cmd(run), .out_freq(freq), .out_rev(orev), .ramp_state(ramp));
	// standard variant shares every input; only refusals and selection are compared
	dss_selector #(.ADVANCED_IO(1'b0), .DEB_CYC(4)) dut_std (.clk(clk), .srst(srst),
		.cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_data(cfg_data), .cfg_err(err_std),
		.primary_pair(), .secondary_pair(), .input_function_cfg(), .digital_input_pins(pins),
		.forward_run_input(fwd), .reverse_run_input(rev), .key_run_press(kr),
		.key_stop_press(ks), .key_rev(krev), .ser_run(ser_run), .ser_rev(ser_rev),
		.refs(refs), .acc_step_cyc(acc), .dec_step_cyc(acc),
		.alt_source_select_function(alt_std), .alt_selector_assigned(), .active_pair(),
		.run_cmd(), .out_freq(), .out_rev(), .ramp_state());
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input int a, input int d);
		logic ok;
		logic ok_std;
		ok = (a == 0 || a == 2) ? d <= 3 : (a == 1 || a == 3) ? d <= 10 : a <= 8 && d <= 27;
		ok_std = (a == 0 || a == 2) ? d <= 2 : (a == 1 || a == 3) ?
			d <= 10 && !(d inside {[4:7], 9}) : a <= 6 && d <= 27;
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_addr <= a[3:0];
		cfg_data <= d[4:0];
		@(posedge clk);
		cfg_wr <= 1'b0;
		if (ok && a == 0) mpri = d * 16 + mpri % 16;
		if (ok && a == 1) mpri = mpri - mpri % 16 + d;
		if (ok && a == 2) msec = d * 16 + msec % 16;
		if (ok && a == 3) msec = msec - msec % 16 + d;
		#1;
		chk("cfg_err", cfg_err, !ok);
		chk("cfg_err_std", err_std, !ok_std);
		chk("primary", pri, mpri);
		chk("secondary", sec, msec);
		if (ok && a > 3) chk("function", fn[a-4], d);
	endtask : wr
	task automatic sel(input logic [4:0] p);
		@(posedge clk);
		pins <= p;
		repeat (20) @(posedge clk);
		#1;
	endtask : sel
	task automatic wait_freq(input logic [15:0] f);
		for (int n = 0; n < 300 && freq !== f; n++) begin
			@(posedge clk);
			#1;
		end
		#1;
		chk("out_freq", freq, f);
	endtask : wait_freq
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		level <= 16'h2 + ($random(seed) & 16'h3);
		@(posedge clk);
		#1;
		chk("primary_rst", pri, 16'h10);
		chk("secondary_rst", sec, 16'h10);
		for (int d = 0; d < 5; d++) wr(2, d);
		for (int d = 0; d < 12; d++) wr(3, d);
		for (int a = 4; a < 10; a++) begin
			wr(a, 28);
			wr(a, 27);
			wr(a, 0);
		end
		sel($random(seed));
		chk("alt_none", alt, 1'b0);
		chk("active_none", act, mpri);
		wr(0, 1);
		wr(1, 2);
		wr(2, 1);
		wr(3, 0);
		sel(5'h00);
		@(posedge clk) fwd <= 1'b1;
		wait_freq(level);
		wr(8, 22);
		chk("assigned", assigned, 1'b1);
		sel(5'h10);
		chk("alt_on", alt, 1'b1);
		chk("alt_std", alt_std, 1'b0);
		chk("active_sec", act, msec);
		chk("ramp_keep", ramp, DSS_RAMP_HOLD);
		wr(0, 3);
		sel(5'h00);
		chk("active_pri", act, mpri);
		wait_freq(16'h0);
		@(posedge clk) ser_on <= 1'b1;
		wait_freq(level);
		@(posedge clk) fwd <= 1'b0;
		sel(5'h10);
		chk("active_sec2", act, msec);
		wait_freq(16'h0);
		wr(0, 2);
		wr(1, 8);
		@(posedge clk) fwd <= 1'b1;
		@(posedge clk) rev <= 1'b1;
		sel(5'h10);
		chk("run_cancel", run, 2'h0);
		sel(5'h00);
		chk("run_dir", run, 2'h3);
		wait_freq({level[14:0], 1'b0});
		chk("rev_dir", orev, 1'b1);
		wr(0, 0);
		wait_freq(16'h0);
		@(posedge clk) kr <= 1'b1;
		@(posedge clk) kr <= 1'b0;
		wait_freq({level[14:0], 1'b0});
		chk("run_key", run, 2'h2);
		chk("fwd_key", orev, 1'b0);
		@(posedge clk) krev <= 1'b1;
		wait_freq(16'h0);
		wait_freq({level[14:0], 1'b0});
		chk("rev_key", orev, 1'b1);
		@(posedge clk) ks <= 1'b1;
		@(posedge clk) ks <= 1'b0;
		wait_freq(16'h0);
		chk("stop_key", run, 2'h1);
		report_and_stop();
	end
endmodule : tb_dss_selector
bind dss_selector dss_selector_chk chk (.clk, .srst, .cfg_wr, .cfg_addr, .cfg_data, .cfg_err,
	.primary_pair, .secondary_pair, .input_function_cfg, .alt_source_select_function,
	.alt_selector_assigned, .active_pair, .out_freq, .ramp_state);
